// ### hw/or_rotate_pkg.sv
// Package: opcodes, states, widths, reset values and helpers for the OR/rotate/return datapath.
// Assumes the sequencer decodes opcodes into op_t before issuing them.
package or_rotate_pkg;

	// ------------------------------------------------------------
	// Widths and reset values
	// ------------------------------------------------------------
	localparam int DATA_W = 8;
	localparam int PC_W = 11;
	localparam logic [7:0] ACC_RST = 8'h00;
	localparam logic [10:0] PC_RST = 11'h000;
	localparam logic ZERO_RST = 1'b0;
	localparam logic CARRY_RST = 1'b0;
	localparam logic MIE_RST = 1'b0;
	localparam logic [10:0] PC_STEP = 11'h001;
	localparam int MSB_POS = 7;
	localparam int LSB_POS = 0;

	// ------------------------------------------------------------
	// Instruction and state encodings
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		idle_instruction = 4'h0,
		or_mem_into_acc = 4'h1,
		or_imm_into_acc = 4'h2,
		or_acc_into_memory = 4'h3,
		subroutine_exit = 4'h4,
		subroutine_exit_with_literal = 4'h5,
		interrupt_exit = 4'h6,
		rotate_left_memory = 4'h7,
		rotate_left_to_acc = 4'h8,
		rotate_left_through_carry = 4'h9
	} op_t;

	// Path idle -> request -> data -> idle; one-bit steps except data -> idle, which flips both bits
	typedef enum logic [1:0] {
		st_idle = 2'b00,
		st_req = 2'b01,
		st_data = 2'b11
	} state_t;

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	// True for the forms that read a data memory byte
	function automatic logic needs_mem(input op_t op);
		needs_mem = (op == or_mem_into_acc) || (op == or_acc_into_memory) ||
			(op == rotate_left_memory) || (op == rotate_left_to_acc) ||
			(op == rotate_left_through_carry);
	endfunction : needs_mem

	function automatic logic is_zero(input logic [7:0] v);
		is_zero = (v == 8'h00);
	endfunction : is_zero

	// One-place left rotate with a chosen fill bit
	function automatic logic [7:0] rot_left(input logic [7:0] v, input logic fill);
		rot_left = {v[MSB_POS-1:LSB_POS], fill};
	endfunction : rot_left

endpackage : or_rotate_pkg

// ### hw/alu_if.sv
// Interface: carries one operation between the core sequencer and its logic unit.
// Assumes both ends share the core clock; the signals are purely combinational.
`timescale 1ns/1ps
interface alu_if;
	import or_rotate_pkg::*;
	op_t op;
	logic [7:0] acc;
	logic [7:0] opnd;
	logic cin;
	logic [7:0] res;
	logic cout;
	logic acc_we;
	logic mem_we;
	logic z_we;
	logic c_we;
	modport unit (input op, acc, opnd, cin, output res, cout, acc_we, mem_we, z_we, c_we);
	modport core (output op, acc, opnd, cin, input res, cout, acc_we, mem_we, z_we, c_we);
endinterface : alu_if

// ### hw/or_rotate_unit.sv
// Logic unit: result, carry and write enables for each OR, rotate and literal form.
// Assumes the caller muxes the operand (memory byte or immediate) before it arrives.
`timescale 1ns/1ps
module or_rotate_unit
	import or_rotate_pkg::*;
(
	alu_if.unit u // Operation in, result out
);

	// ------------------------------------------------------------
	// Result and write enables
	// ------------------------------------------------------------
	// Default is a write-nothing result so unlisted forms touch no state
	always_comb begin
		u.res = u.acc;
		u.cout = u.cin;
		u.acc_we = 1'b0;
		u.mem_we = 1'b0;
		u.z_we = 1'b0;
		u.c_we = 1'b0;
		unique case (u.op)
			or_mem_into_acc, or_imm_into_acc: begin
				u.res = u.acc | u.opnd;
				u.acc_we = 1'b1;
				u.z_we = 1'b1;
			end
			or_acc_into_memory: begin
				u.res = u.acc | u.opnd;
				u.mem_we = 1'b1;
				u.z_we = 1'b1;
			end
			subroutine_exit_with_literal: begin
				u.res = u.opnd;
				u.acc_we = 1'b1;
			end
			rotate_left_memory: begin
				u.res = rot_left(u.opnd, u.opnd[MSB_POS]);
				u.mem_we = 1'b1;
			end
			rotate_left_to_acc: begin
				u.res = rot_left(u.opnd, u.opnd[MSB_POS]);
				u.acc_we = 1'b1;
			end
			rotate_left_through_carry: begin
				u.res = rot_left(u.opnd, u.cin);
				u.cout = u.opnd[MSB_POS];
				u.mem_we = 1'b1;
				u.c_we = 1'b1;
			end
			default: begin
				u.res = u.acc; // Idle and plain returns write nothing
			end
		endcase
	end

endmodule : or_rotate_unit

// ### hw/or_rotate_return_exec.sv
// Top: executes the idle, OR, return and left-rotate instructions of an 8-bit core.
// Assumes a sequencer issuing one op per i_valid pulse while o_busy is low, a data
// memory answering a read one cycle after o_mem_rd, and a return stack showing its top.
`timescale 1ns/1ps
// Behaviour
// - Idle instruction changes nothing, PC advances
// - OR memory into accumulator, zero flag only
// - OR literal into accumulator, zero flag only
// - OR into memory, accumulator kept, zero only
// - Return reloads PC from stack, no flags
// - Literal return reloads PC, loads accumulator
// - Interrupt return reloads PC, sets master enable
// - Pending interrupt served before main program resumes
// - Rotate memory left in place, flags untouched
// - Rotate left into accumulator, memory kept
// - Rotate memory through carry, memory and carry change
module or_rotate_return_exec
	import or_rotate_pkg::*;
(
	input wire logic i_clk, // Core clock, 20 MHz
	input wire logic i_rstn, // Asynchronous reset, active low
	input wire logic i_valid, // Issue pulse, taken while not busy
	input wire op_t i_op, // Decoded instruction
	input wire logic [7:0] i_imm, // Immediate byte
	input wire logic [7:0] i_addr, // Data memory address
	input wire logic [7:0] i_mem_rdata, // Read data, cycle after o_mem_rd
	input wire logic [10:0] i_stack_top, // Top of return stack
	input wire logic i_irq_pending, // Interrupt request waiting
	output logic o_busy, // Instruction in progress
	output logic o_done, // Instruction finished pulse
	output logic [7:0] o_acc, // Accumulator
	output logic o_zero, // Zero flag
	output logic o_carry, // Carry flag
	output logic o_master_irq_enable, // Master interrupt enable
	output logic [10:0] o_pc, // Program counter
	output logic o_mem_rd, // Memory read strobe
	output logic o_mem_wr, // Memory write strobe
	output logic [7:0] o_mem_addr, // Memory address
	output logic [7:0] o_mem_wdata, // Memory write data
	output logic o_stack_pop, // Pop return stack pulse
	output logic o_irq_service // Enter pending interrupt pulse
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	state_t state_q, state_d;
	op_t op_q, op_d;
	logic [7:0] imm_q, imm_d;
	logic [7:0] acc_q, acc_d;
	logic zero_q, zero_d;
	logic carry_q, carry_d;
	logic mie_q, mie_d;
	logic [10:0] pc_q, pc_d;
	logic busy_q, busy_d;
	logic done_q, done_d;
	logic rd_q, rd_d;
	logic wr_q, wr_d;
	logic [7:0] addr_q, addr_d;
	logic [7:0] wdata_q, wdata_d;
	logic pop_q, pop_d;
	logic svc_q, svc_d;
	logic take;
	logic exec;
	op_t exec_op;

	alu_if u_if ();

	or_rotate_unit u_unit (
		.u(u_if.unit)
	);

	// ------------------------------------------------------------
	// Operand select
	// ------------------------------------------------------------
	// Memory forms execute in the data state; the rest in the issue cycle
	assign take = (state_q == st_idle) && i_valid;
	assign exec_op = (state_q == st_data) ? op_q : i_op;
	assign exec = (take && !needs_mem(i_op)) || (state_q == st_data);
	assign u_if.op = exec_op;
	assign u_if.acc = acc_q;
	assign u_if.opnd = (state_q == st_data) ? i_mem_rdata : i_imm;
	assign u_if.cin = carry_q;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	// Requests while busy are ignored; the sequencer must watch o_busy
	always_comb begin
		state_d = state_q;
		op_d = op_q;
		imm_d = imm_q;
		acc_d = acc_q;
		zero_d = zero_q;
		carry_d = carry_q;
		mie_d = mie_q;
		pc_d = pc_q;
		done_d = 1'b0;
		rd_d = 1'b0;
		wr_d = 1'b0;
		addr_d = addr_q;
		wdata_d = wdata_q;
		pop_d = 1'b0;
		svc_d = 1'b0;
		unique case (state_q)
			st_idle: begin
				if (take) begin
					op_d = i_op;
					imm_d = i_imm;
					addr_d = i_addr;
					if (needs_mem(i_op)) begin
						rd_d = 1'b1;
						state_d = st_req;
					end
				end
			end
			st_req: begin
				state_d = st_data;
			end
			st_data: begin
				state_d = st_idle;
			end
			default: begin
				state_d = st_idle; // Illegal code recovers to idle
			end
		endcase
		if (exec) begin
			done_d = 1'b1;
			if (u_if.acc_we) begin
				acc_d = u_if.res;
			end
			if (u_if.z_we) begin
				zero_d = is_zero(u_if.res);
			end
			if (u_if.c_we) begin
				carry_d = u_if.cout;
			end
			if (u_if.mem_we) begin
				wr_d = 1'b1;
				wdata_d = u_if.res;
			end
			unique case (exec_op)
				subroutine_exit, subroutine_exit_with_literal: begin
					pc_d = i_stack_top;
					pop_d = 1'b1;
				end
				interrupt_exit: begin
					pc_d = i_stack_top;
					pop_d = 1'b1;
					mie_d = 1'b1;
					svc_d = i_irq_pending;
				end
				default: begin
					pc_d = pc_q + PC_STEP;
				end
			endcase
		end
		busy_d = (state_d != st_idle);
	end

	// Registers only; outputs come straight from these
	always_ff @(posedge i_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= st_idle;
			op_q <= idle_instruction;
			imm_q <= ACC_RST;
			acc_q <= ACC_RST;
			zero_q <= ZERO_RST;
			carry_q <= CARRY_RST;
			mie_q <= MIE_RST;
			pc_q <= PC_RST;
			busy_q <= 1'b0;
			done_q <= 1'b0;
			rd_q <= 1'b0;
			wr_q <= 1'b0;
			addr_q <= ACC_RST;
			wdata_q <= ACC_RST;
			pop_q <= 1'b0;
			svc_q <= 1'b0;
		end else begin
			state_q <= state_d;
			op_q <= op_d;
			imm_q <= imm_d;
			acc_q <= acc_d;
			zero_q <= zero_d;
			carry_q <= carry_d;
			mie_q <= mie_d;
			pc_q <= pc_d;
			busy_q <= busy_d;
			done_q <= done_d;
			rd_q <= rd_d;
			wr_q <= wr_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			pop_q <= pop_d;
			svc_q <= svc_d;
		end
	end

	assign o_busy = busy_q;
	assign o_done = done_q;
	assign o_acc = acc_q;
	assign o_zero = zero_q;
	assign o_carry = carry_q;
	assign o_master_irq_enable = mie_q;
	assign o_pc = pc_q;
	assign o_mem_rd = rd_q;
	assign o_mem_wr = wr_q;
	assign o_mem_addr = addr_q;
	assign o_mem_wdata = wdata_q;
	assign o_stack_pop = pop_q;
	assign o_irq_service = svc_q;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_rstn);

	sequence s_mem_issue;
		take && needs_mem(i_op);
	endsequence

	sequence s_mem_finish;
		o_mem_rd ##1 !o_mem_rd ##1 o_done;
	endsequence

	a_mem_read_seq: assert property (s_mem_issue |=> s_mem_finish)
		else $error("memory form did not finish two cycles after read");

	a_idle_no_change: assert property (o_done && op_q == idle_instruction |->
		$stable(acc_q) && $stable(zero_q) && $stable(carry_q) && !o_mem_wr &&
		pc_q == $past(pc_q) + PC_STEP)
		else $error("idle instruction changed state");

	a_or_mem_acc: assert property (o_done && op_q == or_mem_into_acc |->
		acc_q == ($past(acc_q) | $past(i_mem_rdata)) && $stable(carry_q) &&
		zero_q == (acc_q == 8'h00))
		else $error("OR memory into accumulator wrong");

	// Literal is taken from the pin at the issue edge, not from the copy kept inside
	a_or_imm_acc: assert property (o_done && op_q == or_imm_into_acc |->
		acc_q == ($past(acc_q) | $past(i_imm)) && $stable(carry_q) &&
		zero_q == (acc_q == 8'h00))
		else $error("OR literal into accumulator wrong");

	a_or_into_mem: assert property (o_done &&
		op_q == or_acc_into_memory |->
		o_mem_wr && o_mem_wdata == ($past(acc_q) | $past(i_mem_rdata)) &&
		$stable(acc_q) && $stable(carry_q) && zero_q == (o_mem_wdata == 8'h00))
		else $error("OR into memory wrong");

	a_return_pc: assert property (o_done && (op_q == subroutine_exit ||
		op_q == subroutine_exit_with_literal) |->
		o_stack_pop && pc_q == $past(i_stack_top) && $stable(zero_q) &&
		$stable(carry_q))
		else $error("return did not reload PC");

	a_return_literal: assert property (o_done &&
		op_q == subroutine_exit_with_literal |-> acc_q == $past(i_imm))
		else $error("literal return did not load accumulator");

	a_int_exit_mie: assert property (o_done && op_q == interrupt_exit |->
		o_master_irq_enable && pc_q == $past(i_stack_top) && o_stack_pop &&
		o_irq_service == $past(i_irq_pending) && $stable(zero_q) && $stable(carry_q))
		else $error("interrupt return wrong");

	a_rot_mem: assert property (o_done && op_q == rotate_left_memory |->
		o_mem_wr && o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])} &&
		$stable(carry_q) && $stable(zero_q) && $stable(acc_q))
		else $error("rotate memory wrong");

	a_rot_acc: assert property (o_done && op_q == rotate_left_to_acc |->
		!o_mem_wr && acc_q == {$past(i_mem_rdata[6:0]), $past(i_mem_rdata[7])} &&
		$stable(carry_q) && $stable(zero_q))
		else $error("rotate into accumulator wrong");

	a_rot_carry: assert property (o_done && op_q == rotate_left_through_carry |->
		o_mem_wr && o_mem_wdata == {$past(i_mem_rdata[6:0]), $past(carry_q)} &&
		carry_q == $past(i_mem_rdata[7]) && $stable(zero_q) && $stable(acc_q))
		else $error("rotate through carry wrong");

	// Outside its own forms each piece of state must hold still; this catches
	// a write enable that leaks into a neighbouring opcode
	a_zero_or_only: assert property (!(o_done &&
		op_q inside {or_mem_into_acc, or_imm_into_acc, or_acc_into_memory}) |->
		$stable(zero_q))
		else $error("zero flag moved outside an OR");

	a_carry_rotate_only: assert property (!(o_done &&
		op_q == rotate_left_through_carry) |-> $stable(carry_q))
		else $error("carry flag moved outside rotate through carry");

	a_mie_exit_only: assert property (!(o_done && op_q == interrupt_exit) |->
		$stable(mie_q))
		else $error("master enable moved outside interrupt return");

	a_acc_write_forms: assert property (!(o_done &&
		op_q inside {or_mem_into_acc, or_imm_into_acc, subroutine_exit_with_literal,
		rotate_left_to_acc}) |-> $stable(acc_q))
		else $error("accumulator moved on a form that keeps it");

	a_wr_mem_forms: assert property (o_mem_wr |-> o_done &&
		op_q inside {or_acc_into_memory, rotate_left_memory, rotate_left_through_carry})
		else $error("memory write on a form that keeps memory");

endmodule : or_rotate_return_exec

// ### dv/mem_model.sv
// Partner model: data memory answering a read one cycle after the read strobe.
// Assumes the block's one-cycle read and write strobes on the core clock.
`timescale 1ns/1ps
module mem_model (
	input wire logic i_clk, // Core clock
	input wire logic i_rd, // Read strobe
	input wire logic i_wr, // Write strobe
	input wire logic [7:0] i_addr, // Byte address
	input wire logic [7:0] i_wdata, // Write data
	output logic [7:0] o_rdata // Read data
);
	logic [7:0] mem [256];

	initial o_rdata = 8'h00;

	// Read bus toggles outside its valid cycle, so a late or early sample is caught
	always @(posedge i_clk) begin
		if (i_rd) begin
			o_rdata <= mem[i_addr];
		end else begin
			o_rdata <= ~o_rdata;
		end
		if (i_wr) begin
			mem[i_addr] <= i_wdata;
		end
	end
endmodule : mem_model

// ### dv/or_rotate_return_exec_bench.sv
// Testbench: runs each instruction form and compares state against a tracked model.
// Assumes the memory partner model and the package of the datapath.
`timescale 1ns/1ps
module or_rotate_return_exec_bench;
	import or_rotate_pkg::*;
	logic i_clk = 1'b0;
	logic i_rstn = 1'b0;
	logic i_valid = 1'b0;
	op_t i_op = idle_instruction;
	logic [7:0] i_imm = 8'h00;
	logic [7:0] i_addr = 8'h00;
	logic [10:0] i_stack_top = 11'h000;
	logic i_irq_pending = 1'b0;
	logic [7:0] i_mem_rdata;
	logic o_busy, o_done, o_zero, o_carry, o_master_irq_enable;
	logic o_mem_rd, o_mem_wr, o_stack_pop, o_irq_service;
	logic [7:0] o_acc, o_mem_addr, o_mem_wdata;
	logic [10:0] o_pc;
	int failures = 0;
	int comparisons = 0;
	logic [7:0] e_acc = ACC_RST;
	logic [10:0] e_pc = PC_RST;
	logic e_z = ZERO_RST;
	logic e_c = CARRY_RST;
	logic e_mie = MIE_RST;

	// 20 MHz core clock
	always #25 i_clk = ~i_clk;

	or_rotate_return_exec DUT (.i_clk(i_clk), .i_rstn(i_rstn), .i_valid(i_valid),
		.i_op(i_op), .i_imm(i_imm), .i_addr(i_addr), .i_mem_rdata(i_mem_rdata),
		.i_stack_top(i_stack_top), .i_irq_pending(i_irq_pending), .o_busy(o_busy),
		.o_done(o_done), .o_acc(o_acc), .o_zero(o_zero), .o_carry(o_carry),
		.o_master_irq_enable(o_master_irq_enable), .o_pc(o_pc), .o_mem_rd(o_mem_rd),
		.o_mem_wr(o_mem_wr), .o_mem_addr(o_mem_addr), .o_mem_wdata(o_mem_wdata),
		.o_stack_pop(o_stack_pop), .o_irq_service(o_irq_service));

	mem_model pm (.i_clk(i_clk), .i_rd(o_mem_rd), .i_wr(o_mem_wr), .i_addr(o_mem_addr),
		.i_wdata(o_mem_wdata), .o_rdata(i_mem_rdata));

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task print_verdict;
		$display("Counts: comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict

	task check(input string name, input logic [10:0] exp, input logic [10:0] got);
		comparisons++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", name, exp, got);
			failures++;
		end
	endtask : check

	task check_state;
		check("acc", 11'(e_acc), 11'(o_acc));
		check("pc", e_pc, o_pc);
		check("zero", 11'(e_z), 11'(o_zero));
		check("carry", 11'(e_c), 11'(o_carry));
		check("mie", 11'(e_mie), 11'(o_master_irq_enable));
	endtask : check_state

	// Issue one op, wait for done under a bound, then judge strobes and state
	task run(input op_t op, input logic [7:0] imm, input logic [7:0] addr,
		input logic [10:0] stk, input logic irq, input logic [7:0] ew);
		int n;
		logic is_exit;
		logic is_wr;
		logic is_mem;
		is_exit = op inside {subroutine_exit, subroutine_exit_with_literal, interrupt_exit};
		is_wr = op inside {or_acc_into_memory, rotate_left_memory, rotate_left_through_carry};
		is_mem = is_wr || op inside {or_mem_into_acc, rotate_left_to_acc};
		n = 0;
		@(posedge i_clk);
		i_valid <= 1'b1;
		i_op <= op;
		i_imm <= imm;
		i_addr <= addr;
		i_stack_top <= stk;
		i_irq_pending <= irq;
		@(posedge i_clk);
		i_valid <= 1'b0;
		#1;
		// Memory forms show busy and the read strobe one cycle after the issue
		check("busy", 11'(is_mem), 11'(o_busy));
		check("mem_rd", 11'(is_mem), 11'(o_mem_rd));
		if (is_mem) begin
			check("mem_addr_rd", 11'(addr), 11'(o_mem_addr));
		end
		// A timeout counts as a mismatch; the run goes on to the closing report
		while (o_done !== 1'b1) begin
			if (n == 8) begin
				$display("ERROR done expected 1 seen %b", o_done);
				failures++;
				return;
			end
			@(posedge i_clk);
			#1;
			n++;
		end
		check("cycles", is_mem ? 11'h002 : 11'h000, 11'(n));
		check("busy_end", 11'h000, 11'(o_busy));
		check("mem_wr", 11'(is_wr), 11'(o_mem_wr));
		check("stack_pop", 11'(is_exit), 11'(o_stack_pop));
		check("irq_service", 11'(op == interrupt_exit && irq), 11'(o_irq_service));
		if (is_wr) begin
			check("mem_wdata", 11'(ew), 11'(o_mem_wdata));
			check("mem_addr", 11'(addr), 11'(o_mem_addr));
		end
		check_state();
	endtask : run

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task s_idle;
		e_pc = e_pc + PC_STEP;
		run(idle_instruction, 8'hff, 8'h55, 11'h7ff, 1'b1, 8'h00);
	endtask : s_idle

	// Zero literal into a zero accumulator first, so the flag must rise
	task s_or_imm;
		e_pc = e_pc + PC_STEP;
		e_z = 1'b1;
		run(or_imm_into_acc, 8'h00, 8'h00, 11'h000, 1'b0, 8'h00);
		e_pc = e_pc + PC_STEP;
		e_z = 1'b0;
		e_acc = 8'h5a;
		run(or_imm_into_acc, 8'h5a, 8'h00, 11'h000, 1'b0, 8'h00);
	endtask : s_or_imm

	task s_or_mem;
		pm.mem[8'h10] = 8'h81;
		e_pc = e_pc + PC_STEP;
		e_acc = 8'hdb;
		run(or_mem_into_acc, 8'h00, 8'h10, 11'h000, 1'b0, 8'h00);
		pm.mem[8'h20] = 8'h24;
		e_pc = e_pc + PC_STEP;
		run(or_acc_into_memory, 8'h00, 8'h20, 11'h000, 1'b0, 8'hff);
	endtask : s_or_mem

	// A rotate of 0x80 yields zero, yet the zero flag must stay clear
	task s_rotates;
		pm.mem[8'h30] = 8'h81;
		e_pc = e_pc + PC_STEP;
		run(rotate_left_memory, 8'h00, 8'h30, 11'h000, 1'b0, 8'h03);
		pm.mem[8'h31] = 8'hc0;
		e_pc = e_pc + PC_STEP;
		e_acc = 8'h81;
		run(rotate_left_to_acc, 8'h00, 8'h31, 11'h000, 1'b0, 8'h00);
		// A stray write would land one edge after done, so look after that edge
		@(posedge i_clk);
		#1;
		check("mem_kept", 11'h0c0, 11'(pm.mem[8'h31]));
		pm.mem[8'h32] = 8'h80;
		e_pc = e_pc + PC_STEP;
		e_c = 1'b1;
		run(rotate_left_through_carry, 8'h00, 8'h32, 11'h000, 1'b0, 8'h00);
		pm.mem[8'h33] = 8'h01;
		e_pc = e_pc + PC_STEP;
		e_c = 1'b0;
		run(rotate_left_through_carry, 8'h00, 8'h33, 11'h000, 1'b0, 8'h03);
	endtask : s_rotates

	task s_returns;
		e_pc = 11'h123;
		run(subroutine_exit, 8'h00, 8'h00, 11'h123, 1'b0, 8'h00);
		e_pc = 11'h456;
		e_acc = 8'h00;
		run(subroutine_exit_with_literal, 8'h00, 8'h00, 11'h456, 1'b0, 8'h00);
		e_pc = 11'h0a5;
		e_mie = 1'b1;
		run(interrupt_exit, 8'h00, 8'h00, 11'h0a5, 1'b0, 8'h00);
		e_pc = 11'h0b6;
		run(interrupt_exit, 8'h00, 8'h00, 11'h0b6, 1'b1, 8'h00);
	endtask : s_returns

	// Accumulator is zero here, so an all-zero byte must set the flag
	task s_or_zero;
		pm.mem[8'h40] = 8'h00;
		e_pc = e_pc + PC_STEP;
		e_z = 1'b1;
		run(or_acc_into_memory, 8'h00, 8'h40, 11'h000, 1'b0, 8'h00);
	endtask : s_or_zero

	initial begin
		repeat (12) @(posedge i_clk);
		i_rstn <= 1'b1;
		#1;
		check_state();
		s_idle();
		s_or_imm();
		s_or_mem();
		s_rotates();
		s_returns();
		s_or_zero();
		print_verdict();
	end
endmodule : or_rotate_return_exec_bench
